// ===== hw/dpc_top.sv
// Dual pulse counters with shared control register and merged interrupt request.
//
// Operation
// - Two independent 16-bit counters, pulses up to 1 MHz, counting only while enabled.
// - Enable bit starts counting; clearing it holds the value.
// - Each enabled counter increments once per falling edge of its input.
// - Counters are readable and writable one byte at a time.
// - Reset clears both counters and the control register.
// - Pulses during a counter write may be lost; reads never lose them.
// - Wrap from all ones to zero sets overflow flag when irq enabled.
// - Overflow flag set by hardware or software, cleared only by software.
// - All-ones load after clean zero does not flag on next pulse.
// - Control bits: en1, ie1, 0, flag1, en2, ie2, 0, flag2.
// - Flag requests interrupt only with its enable; enables read-write.
// - Counter and clock flags are ORed into the external request.
// - Requests serviced only with external interrupt enable active.
// - Serviced only if no routine runs and no pin request pends.
// - Clock flag set by divider overflow or software, cleared by software.
// - Clock request passes only while its enable bit is one.
`timescale 1ns/100ps
`default_nettype none
`include "dpc_cfg.svh"
module dpc_top (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire dpc_pkg::dpc_apb_req_s apb_req,
    output dpc_pkg::dpc_apb_rsp_s      apb_rsp,
    input  wire logic                  pulse_input_one,
    input  wire logic                  pulse_input_two,
    input  wire logic                  rtc_overflow,
    input  wire logic                  external_irq_pin,
    input  wire logic                  ext_irq_enable,
    input  wire logic                  irq_in_service,
    output logic                       external_irq_req,
    output logic                       irq_service
);
    import dpc_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        dpc_ctrl_s    ctrl;
        dpc_bus_e     phase;
        logic [31:0]  rdata;
        logic         err;
        logic [1:0]   pin_sync;
        logic         irq;
        logic         service;
    } dpc_top_s;
    dpc_top_s    state_reg;
    dpc_top_s    state_next;

    logic        fall_one;
    logic        fall_two;
    logic [15:0] count_one;
    logic [15:0] count_two;
    logic        wrap_one;
    logic        wrap_two;
    logic        wr_strobe;
    logic [7:0]  addr;
    logic [7:0]  wbyte;
    logic [7:0]  ctrl_byte;
    logic [7:0]  rtc_byte;

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function automatic logic [7:0] pack_ctrl(input dpc_ctrl_s c);
        logic [7:0] b;
        b = `DPC_CTRL_RST;
        b[`DPC_BIT_C1_EN]  = c.c1_en;
        b[`DPC_BIT_C1_IE]  = c.c1_ie;
        b[`DPC_BIT_C1_OVF] = c.c1_ovf;
        b[`DPC_BIT_C2_EN]  = c.c2_en;
        b[`DPC_BIT_C2_IE]  = c.c2_ie;
        b[`DPC_BIT_C2_OVF] = c.c2_ovf;
        return b;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a == `DPC_OFF_CTRL || a == `DPC_OFF_C1_LO || a == `DPC_OFF_C1_HI
            || a == `DPC_OFF_C2_LO || a == `DPC_OFF_C2_HI || a == `DPC_OFF_RTC;
    endfunction

    // ****************************************************************
    // Counters.
    // ****************************************************************
    assign addr      = apb_req.paddr[9:2];
    assign wbyte     = apb_req.pwdata[7:0];
    assign wr_strobe = apb_req.psel & apb_req.penable & apb_req.pwrite
                     & (apb_req.paddr[31:10] == 22'h000000) & (apb_req.paddr[1:0] == 2'h0);
    assign ctrl_byte = pack_ctrl(state_reg.ctrl);
    assign rtc_byte  = {6'h00, state_reg.ctrl.rtc_flag, state_reg.ctrl.rtc_ie};

    dpc_edge u_edge_one (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (pulse_input_one),
        .fall    (fall_one)
    );
    dpc_edge u_edge_two (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (pulse_input_two),
        .fall    (fall_two)
    );
    dpc_counter u_count_one (
        .ref_clk (ref_clk),
        .rst     (rst),
        .enable  (state_reg.ctrl.c1_en),
        .fall    (fall_one),
        .wr_lo   (wr_strobe && addr == `DPC_OFF_C1_LO),
        .wr_hi   (wr_strobe && addr == `DPC_OFF_C1_HI),
        .wdata   (wbyte),
        .count   (count_one),
        .wrap    (wrap_one)
    );
    dpc_counter u_count_two (
        .ref_clk (ref_clk),
        .rst     (rst),
        .enable  (state_reg.ctrl.c2_en),
        .fall    (fall_two),
        .wr_lo   (wr_strobe && addr == `DPC_OFF_C2_LO),
        .wr_hi   (wr_strobe && addr == `DPC_OFF_C2_HI),
        .wdata   (wbyte),
        .count   (count_two),
        .wrap    (wrap_two)
    );

    // ****************************************************************
    // Bus, flags and interrupt.
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.pin_sync = {state_reg.pin_sync[0], external_irq_pin};
        unique case (state_reg.phase)
            DPC_IDLE: begin
                if (apb_req.psel && !apb_req.penable) begin
                    state_next.phase = DPC_ACCESS;
                    state_next.err   = !is_mapped(apb_req.paddr[9:2])
                                     || apb_req.paddr[31:10] != 22'h000000
                                     || apb_req.paddr[1:0] != 2'h0;
                    unique case (apb_req.paddr[9:2])
                        `DPC_OFF_CTRL:  state_next.rdata = {24'h000000, ctrl_byte};
                        `DPC_OFF_C1_LO: state_next.rdata = {24'h000000, count_one[7:0]};
                        `DPC_OFF_C1_HI: state_next.rdata = {24'h000000, count_one[15:8]};
                        `DPC_OFF_C2_LO: state_next.rdata = {24'h000000, count_two[7:0]};
                        `DPC_OFF_C2_HI: state_next.rdata = {24'h000000, count_two[15:8]};
                        `DPC_OFF_RTC:   state_next.rdata = {24'h000000, rtc_byte};
                        default:        state_next.rdata = 32'h00000000;
                    endcase
                    if (state_next.err || apb_req.pwrite) begin
                        state_next.rdata = 32'h00000000;
                    end
                end
            end
            DPC_ACCESS: begin
                state_next.phase = DPC_IDLE;
            end
        endcase
        if (wr_strobe && addr == `DPC_OFF_CTRL) begin
            state_next.ctrl.c1_en  = wbyte[`DPC_BIT_C1_EN];
            state_next.ctrl.c1_ie  = wbyte[`DPC_BIT_C1_IE];
            state_next.ctrl.c1_ovf = wbyte[`DPC_BIT_C1_OVF];
            state_next.ctrl.c2_en  = wbyte[`DPC_BIT_C2_EN];
            state_next.ctrl.c2_ie  = wbyte[`DPC_BIT_C2_IE];
            state_next.ctrl.c2_ovf = wbyte[`DPC_BIT_C2_OVF];
        end
        if (wr_strobe && addr == `DPC_OFF_RTC) begin
            state_next.ctrl.rtc_ie   = wbyte[`DPC_BIT_RTC_IE];
            state_next.ctrl.rtc_flag = wbyte[`DPC_BIT_RTC_FLAG];
        end
        // Hardware sets win over a software clear in the same cycle.
        if (wrap_one && state_reg.ctrl.c1_ie) begin
            state_next.ctrl.c1_ovf = 1'b1;
        end
        if (wrap_two && state_reg.ctrl.c2_ie) begin
            state_next.ctrl.c2_ovf = 1'b1;
        end
        if (rtc_overflow) begin
            state_next.ctrl.rtc_flag = 1'b1;
        end
        state_next.irq = state_reg.pin_sync[1]
                       | (state_reg.ctrl.c1_ovf & state_reg.ctrl.c1_ie)
                       | (state_reg.ctrl.c2_ovf & state_reg.ctrl.c2_ie)
                       | (state_reg.ctrl.rtc_flag & state_reg.ctrl.rtc_ie);
        state_next.service = ext_irq_enable & ~irq_in_service & ~state_reg.pin_sync[1]
                           & ((state_reg.ctrl.c1_ovf & state_reg.ctrl.c1_ie)
                           | (state_reg.ctrl.c2_ovf & state_reg.ctrl.c2_ie)
                           | (state_reg.ctrl.rtc_flag & state_reg.ctrl.rtc_ie));
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= '{ctrl: '0, phase: DPC_IDLE, rdata: 32'h00000000, err: 1'b0,
                           pin_sync: 2'h0, irq: 1'b0, service: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign apb_rsp.pready   = state_reg.phase == DPC_ACCESS;
    assign apb_rsp.pslverr  = state_reg.phase == DPC_ACCESS && state_reg.err;
    assign apb_rsp.prdata   = state_reg.rdata;
    assign external_irq_req = state_reg.irq;
    assign irq_service      = state_reg.service;
endmodule
`default_nettype wire

// ===== hw/dpc_cfg.svh
// Register offsets, field positions, reset values and write masks of the pulse counters.
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH
`define DPC_OFF_CTRL      8'h40
`define DPC_OFF_C1_LO     8'h41
`define DPC_OFF_C1_HI     8'h42
`define DPC_OFF_C2_LO     8'h43
`define DPC_OFF_C2_HI     8'h44
`define DPC_OFF_RTC       8'h48
`define DPC_BIT_C1_EN     7
`define DPC_BIT_C1_IE     6
`define DPC_BIT_C1_OVF    4
`define DPC_BIT_C2_EN     3
`define DPC_BIT_C2_IE     2
`define DPC_BIT_C2_OVF    0
`define DPC_BIT_RTC_IE    0
`define DPC_BIT_RTC_FLAG  1
`define DPC_CTRL_RST      8'h00
`define DPC_CNT_RST       16'h0000
`define DPC_CTRL_WMASK    8'hdd
`define DPC_RTC_WMASK     8'h03
`endif

// ===== hw/dpc_pkg.sv
// Types shared by the dual pulse counter design.
package dpc_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } dpc_apb_req_s;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } dpc_apb_rsp_s;
    typedef struct packed {
        logic [15:0] count;
        logic        wrapped_clean;
    } dpc_cnt_s;
    typedef struct packed {
        logic [2:0] sync;
    } dpc_edge_s;
    typedef struct packed {
        logic c1_en;
        logic c1_ie;
        logic c1_ovf;
        logic c2_en;
        logic c2_ie;
        logic c2_ovf;
        logic rtc_ie;
        logic rtc_flag;
    } dpc_ctrl_s;
    typedef enum logic [1:0] {
        DPC_IDLE,
        DPC_ACCESS
    } dpc_bus_e;
endpackage

// ===== hw/dpc_edge.sv
// Pin synchroniser and falling edge detector for one pulse input.
`timescale 1ns/100ps
`default_nettype none
module dpc_edge (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      fall
);
    import dpc_pkg::*;
    dpc_edge_s state_reg;
    dpc_edge_s state_next;
    always_comb begin
        state_next = {state_reg.sync[1:0], pin};
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    // Only the second and third stages feed the edge test.
    assign fall = state_reg.sync[2] & ~state_reg.sync[1];
endmodule
`default_nettype wire

// ===== hw/dpc_counter.sv
// One 16-bit pulse counter with byte-wise software load.
`timescale 1ns/100ps
`default_nettype none
module dpc_counter (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        enable,
    input  wire logic        fall,
    input  wire logic        wr_lo,
    input  wire logic        wr_hi,
    input  wire logic [7:0]  wdata,
    output logic      [15:0] count,
    output logic             wrap
);
    import dpc_pkg::*;
    dpc_cnt_s state_reg;
    dpc_cnt_s state_next;
    logic     inc;
    always_comb begin
        state_next = state_reg;
        inc        = enable & fall & ~(wr_lo | wr_hi);
        if (wr_lo | wr_hi) begin
            if (wr_lo) begin
                state_next.count[7:0] = wdata;
            end
            if (wr_hi) begin
                state_next.count[15:8] = wdata;
            end
            // Byte loads of all ones keep a clean zero clean, so an all-ones load in two steps.
            // Still gives no flag on the next wrap.
            if (wdata != 8'hff) begin
                state_next.wrapped_clean = 1'b0;
            end
        end else if (inc) begin
            state_next.count         = state_reg.count + 16'h0001;
            state_next.wrapped_clean = (state_reg.count == 16'hffff);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= '{count: 16'h0000, wrapped_clean: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end
    assign count = state_reg.count;
    // Wraps after an all-ones load from a clean zero are suppressed.
    assign wrap  = inc && state_reg.count == 16'hffff && !state_reg.wrapped_clean;
endmodule
`default_nettype wire

// ===== tb/dpc_props.sv
// Concurrent checks on the ports of the dual pulse counter block.
`timescale 1ns/100ps
`default_nettype none
module dpc_props (
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire dpc_pkg::dpc_apb_req_s apb_req,
    input wire dpc_pkg::dpc_apb_rsp_s apb_rsp,
    input wire logic                  external_irq_pin,
    input wire logic                  ext_irq_enable,
    input wire logic                  irq_in_service,
    input wire logic                  external_irq_req,
    input wire logic                  irq_service
);
    import dpc_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_pin_held;
        external_irq_pin [*4];
    endsequence
    property p_ready;
        s_setup |=> apb_rsp.pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready missing after setup");
    property p_ready_once;
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready held");
    property p_err_pair;
        apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0;
    endproperty
    a_err_pair: assert property (p_err_pair) else $error("bad error answer");
    property p_rst_clear;
        $fell(rst) |-> !external_irq_req && !irq_service && apb_rsp.prdata == 32'h0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("not clear after reset");
    property p_ctrl_zero;
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 32'h100
            |-> apb_rsp.prdata[31:8] == 24'h0 && !apb_rsp.prdata[5] && !apb_rsp.prdata[1];
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused bit set");
    property p_pin_req;
        s_pin_held |=> external_irq_req;
    endproperty
    a_pin_req: assert property (p_pin_req) else $error("pin request lost");
    property p_svc_enable;
        !ext_irq_enable |=> !irq_service;
    endproperty
    a_svc_enable: assert property (p_svc_enable) else $error("served while off");
    property p_svc_busy;
        irq_in_service |=> !irq_service;
    endproperty
    a_svc_busy: assert property (p_svc_busy) else $error("served in routine");
    property p_svc_pin;
        s_pin_held |=> !irq_service;
    endproperty
    a_svc_pin: assert property (p_svc_pin) else $error("served over pin");
    property p_svc_req;
        irq_service |-> external_irq_req;
    endproperty
    a_svc_req: assert property (p_svc_req) else $error("service without request");
endmodule
bind dpc_top dpc_props dpc_props_inst (.ref_clk(ref_clk), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .external_irq_pin(external_irq_pin), .ext_irq_enable(ext_irq_enable),
    .irq_in_service(irq_in_service), .external_irq_req(external_irq_req),
    .irq_service(irq_service));
`default_nettype wire

// ===== tb/dpc_pulse_src.sv
// Behavioural pulse source standing in for a metering sensor.
`timescale 1ns/100ps
`default_nettype none
module dpc_pulse_src (
    input  wire logic ref_clk,
    output logic      pulse
);
    initial pulse = 1'b1;
    // The low phase lasts half clocks, the high phase half plus one, and the line idles high between bursts.
    task automatic burst(input int n, input int half);
        repeat (n) begin
            @(posedge ref_clk);
            pulse <= 1'b0;
            repeat (half) @(posedge ref_clk);
            pulse <= 1'b1;
            repeat (half) @(posedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the dual pulse counter block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import dpc_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    dpc_apb_req_s apb_req = '0;
    dpc_apb_rsp_s apb_rsp;
    logic         pulse_input_one, pulse_input_two, external_irq_req, irq_service;
    logic         rtc_overflow = 1'b0;
    logic         external_irq_pin = 1'b0;
    logic         ext_irq_enable = 1'b1;
    logic         irq_in_service = 1'b0;
    logic [31:0]  rd;
    logic         err;
    int           n_errors = 0;
    int           comparisons = 0;
    always #5 ref_clk = ~ref_clk;
    dpc_top dpc_top_inst (.ref_clk(ref_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .pulse_input_one(pulse_input_one), .pulse_input_two(pulse_input_two),
        .rtc_overflow(rtc_overflow), .external_irq_pin(external_irq_pin),
        .ext_irq_enable(ext_irq_enable), .irq_in_service(irq_in_service),
        .external_irq_req(external_irq_req), .irq_service(irq_service));
    dpc_pulse_src dpc_pulse_src_inst (.ref_clk(ref_clk), .pulse(pulse_input_one));
    dpc_pulse_src dpc_pulse_src_two_inst (.ref_clk(ref_clk), .pulse(pulse_input_two));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        int i;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (apb_rsp.pready !== 1'b1 && i < 20);
        if (apb_rsp.pready !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t: no bus answer", $time);
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge ref_clk);
        check({31'h0, apb_rsp.pready}, 32'h0);
    endtask
    task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask
    task automatic pulses(input int i, input int n);
        if (i == 0) dpc_pulse_src_inst.burst(n, 3);
        else dpc_pulse_src_two_inst.burst(n, 3);
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic t_ctrl;
        for (int a = 0; a < 5; a++) rdchk(32'h100 + 32'(4 * a), 32'h0);
        apb(1'b1, 32'h100, 32'hff);
        rdchk(32'h100, 32'hdd);
        repeat (2) @(posedge ref_clk);
        check({30'h0, external_irq_req, irq_service}, 32'h3);
        irq_in_service <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({31'h0, irq_service}, 32'h0);
        irq_in_service <= 1'b0;
        ext_irq_enable <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, irq_service}, 32'h0);
        ext_irq_enable <= 1'b1;
        apb(1'b1, 32'h100, 32'h11);
        repeat (2) @(posedge ref_clk);
        check({31'h0, external_irq_req}, 32'h0);
        apb(1'b1, 32'h100, 32'h0);
        rdchk(32'h100, 32'h0);
        $display("control test done");
    endtask
    task automatic t_count;
        apb(1'b1, 32'h100, 32'h80);
        pulses(0, 5);
        fork
            pulses(0, 1);
            apb(1'b0, 32'h104, 32'h0);
        join
        pulses(1, 3);
        apb(1'b1, 32'h100, 32'h08);
        pulses(1, 4);
        apb(1'b1, 32'h100, 32'h0);
        rdchk(32'h104, 32'h6);
        rdchk(32'h10c, 32'h4);
        pulses(0, 2);
        rdchk(32'h104, 32'h6);
        $display("count test done");
    endtask
    task automatic t_wrap;
        logic [31:0] lo, en, fl;
        for (int i = 0; i < 2; i++) begin
            lo = 32'h104 + 32'(8 * i);
            en = (i == 0) ? 32'hc0 : 32'h0c;
            fl = (i == 0) ? 32'h10 : 32'h01;
            apb(1'b1, 32'h100, 32'h0);
            apb(1'b1, lo, 32'hfe);
            apb(1'b1, lo + 32'h4, 32'hff);
            rdchk(lo, 32'hfe);
            rdchk(lo + 32'h4, 32'hff);
            apb(1'b1, 32'h100, en);
            pulses(i, 2);
            rdchk(32'h100, en | fl);
            rdchk(lo, 32'h0);
            apb(1'b1, 32'h100, 32'h0);
            apb(1'b1, lo, 32'hff);
            apb(1'b1, lo + 32'h4, 32'hff);
            apb(1'b1, 32'h100, en);
            pulses(i, 1);
            rdchk(32'h100, en);
        end
        apb(1'b1, 32'h100, 32'h0);
        $display("wrap test done");
    endtask
    task automatic t_rtc;
        rtc_overflow <= 1'b1;
        @(posedge ref_clk);
        rtc_overflow <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rdchk(32'h120, 32'h2);
        check({31'h0, external_irq_req}, 32'h0);
        apb(1'b1, 32'h120, 32'h3);
        repeat (2) @(posedge ref_clk);
        check({31'h0, external_irq_req}, 32'h1);
        apb(1'b1, 32'h120, 32'h0);
        rdchk(32'h120, 32'h0);
        external_irq_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check({30'h0, external_irq_req, irq_service}, 32'h2);
        rdchk(32'h100, 32'h0);
        external_irq_pin <= 1'b0;
        apb(1'b0, 32'h0fc, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("clock flag test done");
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        $display("[FAIL] %0t: watchdog expired", $time);
        results;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_ctrl;
        t_count;
        t_wrap;
        t_rtc;
        results;
    end
endmodule
`default_nettype wire
